// >>> ccp_capture_compare_unit.sv
// Capture/compare unit with its own 16-bit timer and an Avalon-MM register slave.
// Assumes pin and tick inputs are synchronous to clock; the pin still gets two flops.
`timescale 1ns/1ps
`default_nettype none
module ccp_capture_compare_unit #(
  parameter bit SECOND_UNIT = 1'b0
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  // Pin
  input  wire logic        capcmp_pin_in,
  output var  logic        capcmp_pin_out,
  output var  logic        capcmp_pin_oe_n,
  // Timer sources and power state
  input  wire logic        ext_tick,
  input  wire logic        sleep,
  // Converter and events
  input  wire logic        adc_enable,
  output var  logic        adc_start,
  output var  logic        special_trigger,
  output var  logic        capcmp_irq_flag,
  output var  logic        timer_overflow_flag
);

  // ---------------------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------------------
  ccp_pkg::ccp_bus_req_s req;
  logic        wait_ff;
  logic [31:0] rdata_ff;
  logic        nxt_wait;
  logic [31:0] nxt_rdata;
  logic        wr_go;

  logic [3:0]  mode_ff;
  logic [15:0] value_ff;
  logic [15:0] timer_ff;
  ccp_pkg::ccp_tctrl_s tctrl_ff;
  logic        flag_ff;
  logic        ovf_ff;

  // A request is answered one cycle after it is first seen, so every access
  // costs exactly two edges; this keeps read data registered.
  always_comb begin
    req       = '{read: avs_read, write: avs_write, address: avs_address,
                  writedata: avs_writedata};
    nxt_wait  = ~((req.read | req.write) & wait_ff);
    wr_go     = req.write & ~wait_ff;
    nxt_rdata = 32'h0000_0000;
    case (req.address)
      ccp_pkg::CTRL_OFS:       nxt_rdata[3:0]  = mode_ff;
      ccp_pkg::VALUE_LOW_OFS:  nxt_rdata[7:0]  = value_ff[7:0];
      ccp_pkg::VALUE_HIGH_OFS: nxt_rdata[7:0]  = value_ff[15:8];
      ccp_pkg::FLAGS_OFS:      nxt_rdata[1:0]  = {ovf_ff, flag_ff};
      ccp_pkg::TIMER_LOW_OFS:  nxt_rdata[7:0]  = timer_ff[7:0];
      ccp_pkg::TIMER_HIGH_OFS: nxt_rdata[7:0]  = timer_ff[15:8];
      ccp_pkg::TIMER_CTRL_OFS: nxt_rdata[1:0]  = {tctrl_ff.ext_src, tctrl_ff.timer_on};
      default:                 nxt_rdata       = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wait_ff  <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      wait_ff  <= nxt_wait;
      rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Pin synchroniser and capture prescaler
  // ---------------------------------------------------------------------------
  logic sync1_ff;
  logic sync2_ff;
  logic cap_mode;
  logic cap_evt;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= capcmp_pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  assign cap_mode = (mode_ff[3:2] == 2'b01);

  ccp_edge_prescaler u_prescaler (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .clear    (~cap_mode),
    .sel      (mode_ff[1:0]),
    .pin_sync (sync2_ff),
    .event_ff (cap_evt)
  );

  // ---------------------------------------------------------------------------
  // Timer, compare and control state
  // ---------------------------------------------------------------------------
  logic [1:0]  div_ff;
  logic        match_q_ff;
  logic        pend_ff;
  logic        out_ff;
  logic        oe_n_ff;
  logic        trig_ff;
  logic        adc_ff;

  logic [1:0]  nxt_div;
  logic [3:0]  nxt_mode;
  logic [15:0] nxt_value;
  logic [15:0] nxt_timer;
  ccp_pkg::ccp_tctrl_s nxt_tctrl;
  logic        nxt_flag;
  logic        nxt_ovf;
  logic        nxt_match_q;
  logic        nxt_pend;
  logic        nxt_out;
  logic        nxt_oe_n;
  logic        nxt_trig;
  logic        nxt_adc;

  logic        tick;
  logic        cmp_mode;
  logic        match;
  logic        cmp_evt;
  logic        sev_reset;
  logic        drive_mode;

  always_comb begin
    tick       = tctrl_ff.timer_on &
                 (tctrl_ff.ext_src ? ext_tick
                                   : (~sleep & (div_ff == ccp_pkg::INSTR_LAST)));
    cmp_mode   = mode_ff[3] | (mode_ff == ccp_pkg::MODE_TOGGLE);
    match      = cmp_mode & (timer_ff == value_ff);
    cmp_evt    = match & ~match_q_ff;
    sev_reset  = pend_ff & tick & match;
    drive_mode = (mode_ff == ccp_pkg::MODE_TOGGLE) | (mode_ff == ccp_pkg::MODE_SET) |
                 (mode_ff == ccp_pkg::MODE_CLEAR);

    nxt_div     = (tctrl_ff.ext_src | sleep) ? div_ff : div_ff + 2'd1;
    nxt_mode    = mode_ff;
    nxt_value   = value_ff;
    nxt_timer   = timer_ff;
    nxt_tctrl   = tctrl_ff;
    nxt_flag    = flag_ff;
    nxt_ovf     = ovf_ff;
    nxt_match_q = match;
    nxt_pend    = pend_ff;
    nxt_out     = out_ff;
    nxt_oe_n    = ~drive_mode;
    nxt_trig    = 1'b0;
    nxt_adc     = 1'b0;

    // Timer: software write beats the trigger reset, which beats counting.
    if (sev_reset) begin
      nxt_timer = ccp_pkg::TIMER_RST;
    end else if (tick) begin
      nxt_timer = timer_ff + 16'h0001;
      if (timer_ff == ccp_pkg::TIMER_MAX) begin
        nxt_ovf = 1'b1;
      end
    end
    if (tick) begin
      nxt_pend = 1'b0;
    end

    // Software writes; flags are write-one-to-clear.
    if (wr_go) begin
      case (req.address)
        ccp_pkg::CTRL_OFS: begin
          nxt_mode = req.writedata[3:0];
          if (req.writedata[3:0] == ccp_pkg::MODE_OFF) begin
            nxt_out = 1'b0;
          end
        end
        ccp_pkg::VALUE_LOW_OFS:  nxt_value[7:0]  = req.writedata[7:0];
        ccp_pkg::VALUE_HIGH_OFS: nxt_value[15:8] = req.writedata[7:0];
        ccp_pkg::FLAGS_OFS: begin
          if (req.writedata[ccp_pkg::FLAG_CAPCMP_BIT]) begin
            nxt_flag = 1'b0;
          end
          if (req.writedata[ccp_pkg::FLAG_OVF_BIT]) begin
            nxt_ovf = 1'b0;
          end
        end
        ccp_pkg::TIMER_LOW_OFS:  nxt_timer[7:0]  = req.writedata[7:0];
        ccp_pkg::TIMER_HIGH_OFS: nxt_timer[15:8] = req.writedata[7:0];
        ccp_pkg::TIMER_CTRL_OFS: begin
          nxt_tctrl.timer_on = req.writedata[ccp_pkg::TCTRL_ON_BIT];
          nxt_tctrl.ext_src  = req.writedata[ccp_pkg::TCTRL_EXT_BIT];
        end
        default: nxt_mode = mode_ff;
      endcase
    end

    // Hardware events come last so that a set wins over a same-cycle clear.
    if (tick & ~sev_reset & (timer_ff == ccp_pkg::TIMER_MAX)) begin
      nxt_ovf = 1'b1;
    end
    if (cap_evt & cap_mode) begin
      nxt_value = timer_ff;
      nxt_flag  = 1'b1;
    end
    if (cmp_evt) begin
      nxt_flag = 1'b1;
      case (mode_ff)
        ccp_pkg::MODE_TOGGLE:  nxt_out = ~out_ff;
        ccp_pkg::MODE_SET:     nxt_out = 1'b1;
        ccp_pkg::MODE_CLEAR:   nxt_out = 1'b0;
        ccp_pkg::MODE_SPECIAL: begin
          nxt_trig = 1'b1;
          nxt_pend = 1'b1;
          nxt_adc  = SECOND_UNIT & adc_enable;
        end
        default: nxt_out = out_ff;
      endcase
    end

    // Switching the unit off owns the latch, even against a match in the same cycle.
    if (wr_go & (req.address == ccp_pkg::CTRL_OFS) &
        (req.writedata[3:0] == ccp_pkg::MODE_OFF)) begin
      nxt_out = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      div_ff     <= 2'd0;
      mode_ff    <= ccp_pkg::MODE_RST;
      value_ff   <= ccp_pkg::VALUE_RST;
      timer_ff   <= ccp_pkg::TIMER_RST;
      tctrl_ff   <= ccp_pkg::TCTRL_RST;
      flag_ff    <= 1'b0;
      ovf_ff     <= 1'b0;
      match_q_ff <= 1'b0;
      pend_ff    <= 1'b0;
      out_ff     <= 1'b0;
      oe_n_ff    <= 1'b1;
      trig_ff    <= 1'b0;
      adc_ff     <= 1'b0;
    end else begin
      div_ff     <= nxt_div;
      mode_ff    <= nxt_mode;
      value_ff   <= nxt_value;
      timer_ff   <= nxt_timer;
      tctrl_ff   <= nxt_tctrl;
      flag_ff    <= nxt_flag;
      ovf_ff     <= nxt_ovf;
      match_q_ff <= nxt_match_q;
      pend_ff    <= nxt_pend;
      out_ff     <= nxt_out;
      oe_n_ff    <= nxt_oe_n;
      trig_ff    <= nxt_trig;
      adc_ff     <= nxt_adc;
    end
  end

  assign avs_readdata        = rdata_ff;
  assign avs_waitrequest     = wait_ff;
  assign capcmp_pin_out      = out_ff;
  assign capcmp_pin_oe_n     = oe_n_ff;
  assign adc_start           = adc_ff;
  assign special_trigger     = trig_ff;
  assign capcmp_irq_flag     = flag_ff;
  assign timer_overflow_flag = ovf_ff;

  // ---------------------------------------------------------------------------
  // Assertions and cover points
  // ---------------------------------------------------------------------------
  a_capture_loads_timer: assert property (@(posedge clock) disable iff (sys_rst)
    cap_evt && cap_mode |=> value_ff == $past(timer_ff)) else $error("capture missed timer");

  a_capture_sets_flag: assert property (@(posedge clock) disable iff (sys_rst)
    (cap_evt && cap_mode) || cmp_evt |=> flag_ff) else $error("flag not set");

  a_flag_holds_set: assert property (@(posedge clock) disable iff (sys_rst)
    flag_ff && !(wr_go && req.address == ccp_pkg::FLAGS_OFS && req.writedata[0])
    |=> flag_ff) else $error("flag cleared by hardware");

  a_off_forces_low: assert property (@(posedge clock) disable iff (sys_rst)
    wr_go && req.address == ccp_pkg::CTRL_OFS && req.writedata[3:0] == 4'h0
    |=> !out_ff ##1 !out_ff) else $error("latch not forced low");

  a_swint_no_drive: assert property (@(posedge clock) disable iff (sys_rst)
    mode_ff == ccp_pkg::MODE_SWINT && !wr_go |=> oe_n_ff && $stable(out_ff))
    else $error("pin driven");

  a_trigger_at_match: assert property (@(posedge clock) disable iff (sys_rst)
    cmp_evt && mode_ff == ccp_pkg::MODE_SPECIAL |=> trig_ff && pend_ff) else $error("no trigger");

  a_timer_zeroed: assert property (@(posedge clock) disable iff (sys_rst)
    sev_reset && !wr_go |=> timer_ff == 16'h0000 && ovf_ff == $past(ovf_ff))
    else $error("trigger reset wrong");

  a_cancel_reset: assert property (@(posedge clock) disable iff (sys_rst)
    pend_ff && tick && !match && !wr_go |=> timer_ff == $past(timer_ff) + 16'h0001)
    else $error("reset not cancelled");

  a_sleep_holds: assert property (@(posedge clock) disable iff (sys_rst)
    sleep && !tctrl_ff.ext_src && !wr_go |=> $stable(timer_ff)) else $error("timer ran in sleep");

  a_adc_only_second: assert property (@(posedge clock) disable iff (sys_rst)
    adc_ff |-> SECOND_UNIT && trig_ff) else $error("adc start wrong");

  c_capture_rise: cover property (@(posedge clock) disable iff (sys_rst)
    cap_evt && mode_ff == ccp_pkg::MODE_CAP_RISE);
  c_capture_16: cover property (@(posedge clock) disable iff (sys_rst)
    cap_evt && mode_ff == ccp_pkg::MODE_CAP_16);
  c_toggle_match: cover property (@(posedge clock) disable iff (sys_rst)
    cmp_evt && mode_ff == ccp_pkg::MODE_TOGGLE);
  c_special_reset: cover property (@(posedge clock) disable iff (sys_rst) sev_reset);

endmodule : ccp_capture_compare_unit
`default_nettype wire

// >>> ccp_pkg.sv
// Constants, register map and carrier types for the capture/compare unit.
// Assumes a single 10 MHz clock and an Avalon-MM master on the register side.
package ccp_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [4:0] CTRL_OFS       = 5'h00;
  localparam logic [4:0] VALUE_LOW_OFS  = 5'h04;
  localparam logic [4:0] VALUE_HIGH_OFS = 5'h08;
  localparam logic [4:0] FLAGS_OFS      = 5'h0C;
  localparam logic [4:0] TIMER_LOW_OFS  = 5'h10;
  localparam logic [4:0] TIMER_HIGH_OFS = 5'h14;
  localparam logic [4:0] TIMER_CTRL_OFS = 5'h18;

  localparam int FLAG_CAPCMP_BIT  = 0;
  localparam int FLAG_OVF_BIT     = 1;
  localparam int TCTRL_ON_BIT     = 0;
  localparam int TCTRL_EXT_BIT    = 1;

  // ---------------------------------------------------------------------------
  // Mode field encodings
  // ---------------------------------------------------------------------------
  localparam logic [3:0] MODE_OFF      = 4'h0;
  localparam logic [3:0] MODE_TOGGLE   = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4    = 4'h6;
  localparam logic [3:0] MODE_CAP_16   = 4'h7;
  localparam logic [3:0] MODE_SET      = 4'h8;
  localparam logic [3:0] MODE_CLEAR    = 4'h9;
  localparam logic [3:0] MODE_SWINT    = 4'hA;
  localparam logic [3:0] MODE_SPECIAL  = 4'hB;

  // ---------------------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------------------
  localparam logic [3:0]  MODE_RST     = 4'h0;
  localparam logic [15:0] VALUE_RST    = 16'h0000;
  localparam logic [15:0] TIMER_RST    = 16'h0000;
  localparam logic [15:0] TIMER_MAX    = 16'hFFFF;
  localparam logic [1:0]  TCTRL_RST    = 2'h0;
  localparam int          CLOCK_HZ     = 10_000_000;
  localparam int          INSTR_DIV    = 4;
  localparam logic [1:0]  INSTR_LAST   = 2'(INSTR_DIV - 1);
  localparam logic [3:0]  PRESC_LAST_4 = 4'h3;
  localparam logic [3:0]  PRESC_LAST_16 = 4'hF;

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
  } ccp_bus_req_s;

  typedef struct packed {
    logic timer_on;
    logic ext_src;
  } ccp_tctrl_s;

endpackage : ccp_pkg

// >>> ccp_edge_prescaler.sv
// Edge detector and capture prescaler for the capture/compare unit.
// Assumes pin_sync is already a two-stage synchronised copy of the pin.
`timescale 1ns/1ps
`default_nettype none
module ccp_edge_prescaler (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // Control
  input  wire logic       clear,
  input  wire logic [1:0] sel,
  // Pin and event
  input  wire logic       pin_sync,
  output var  logic       event_ff
);

  logic       prev_ff;
  logic [3:0] count_ff;
  logic       nxt_prev;
  logic [3:0] nxt_count;
  logic       nxt_event;
  logic       rise;
  logic       fall;

  always_comb begin
    rise      = pin_sync & ~prev_ff;
    fall      = ~pin_sync & prev_ff;
    nxt_prev  = pin_sync;
    nxt_count = count_ff;
    nxt_event = 1'b0;
    if (clear) begin
      nxt_count = 4'h0;
    end else begin
      case (sel)
        2'd0: nxt_event = fall;
        2'd1: nxt_event = rise;
        2'd2: begin
          if (rise) begin
            nxt_event = (count_ff[1:0] == ccp_pkg::PRESC_LAST_4[1:0]);
            nxt_count = {2'b00, count_ff[1:0] + 2'd1};
          end
        end
        default: begin
          if (rise) begin
            nxt_event = (count_ff == ccp_pkg::PRESC_LAST_16);
            nxt_count = count_ff + 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prev_ff  <= 1'b0;
      count_ff <= 4'h0;
      event_ff <= 1'b0;
    end else begin
      prev_ff  <= nxt_prev;
      count_ff <= nxt_count;
      event_ff <= nxt_event;
    end
  end

  a_presc_clear: assert property (@(posedge clock) disable iff (sys_rst)
    clear |=> count_ff == 4'h0) else $error("prescaler not cleared");

  a_edge_once: assert property (@(posedge clock) disable iff (sys_rst)
    event_ff |=> !event_ff || $past(sel) != 2'd1) else $error("edge counted twice");

endmodule : ccp_edge_prescaler
`default_nettype wire

// >>> ccp_far_model.sv
// Far-side model for the capture/compare unit: pin driver and external tick source.
// Assumes the bench changes drive_level and tick_req right after rising clock edges.
`timescale 1ns/1ps
`default_nettype none
module ccp_far_model (
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // Bench requests
  input  wire logic drive_level,
  input  wire logic tick_req,
  // Unit side
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  output var  logic pin_in,
  output var  logic ext_tick
);
  // ---------------------------------------------------------------------------
  // Pin and timer source
  // ---------------------------------------------------------------------------
  // The unit's latch owns the wire while it drives it, so the unit sees its own level.
  assign pin_in = pin_oe_n ? drive_level : pin_out;
  // Ticks are clean one-cycle pulses in the unit's clock domain, never the raw clock.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      ext_tick <= 1'b0;
    else
      ext_tick <= tick_req;
  end
endmodule : ccp_far_model
`default_nettype wire

// >>> ccp_capture_compare_unit_bench.sv
// Self-checking bench for the capture/compare unit, second-unit variant.
// Assumes the far-side model in ccp_far_model.sv and one wait cycle per access.
`timescale 1ns/1ps
`default_nettype none
module ccp_capture_compare_unit_bench;
  logic        clock;
  logic        sys_rst;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        pin_in;
  logic        pin_out;
  logic        pin_oe_n;
  logic        ext_tick;
  logic        sleep;
  logic        adc_start;
  logic        special_trigger;
  logic        irq_flag;
  logic        ovf_flag;
  logic        drive_level;
  logic        tick_req;
  int          n_mismatch;
  int          check_count;
  int          trig_cnt = 0;
  int          adc_cnt = 0;
  int          trig_base;
  int          adc_base;
  logic        adc_en;
  logic [3:0]  md [5] = '{ccp_pkg::MODE_SET, ccp_pkg::MODE_CLEAR, ccp_pkg::MODE_TOGGLE,
                          ccp_pkg::MODE_SWINT, ccp_pkg::MODE_SPECIAL};
  logic [4:0]  exp_oe   = 5'h18;
  logic [4:0]  exp_trig = 5'h10;
  logic [4:0]  exp_pin  = 5'h05;

  ccp_capture_compare_unit #(.SECOND_UNIT(1'b1)) uut (
    .clock(clock), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .capcmp_pin_in(pin_in), .capcmp_pin_out(pin_out), .capcmp_pin_oe_n(pin_oe_n),
    .ext_tick(ext_tick), .sleep(sleep), .adc_enable(adc_en), .adc_start(adc_start),
    .special_trigger(special_trigger), .capcmp_irq_flag(irq_flag),
    .timer_overflow_flag(ovf_flag)
  );

  ccp_far_model far (
    .clock(clock), .sys_rst(sys_rst), .drive_level(drive_level), .tick_req(tick_req),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in), .ext_tick(ext_tick)
  );

  // ---------------------------------------------------------------------------
  // Clock and pulse monitor
  // ---------------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock) begin
    if (special_trigger === 1'b1) trig_cnt++;
    if (adc_start === 1'b1) adc_cnt++;
  end

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  // Called right after a rising edge; lets one idle edge pass after the release so that
  // back-to-back calls never drive a strobe twice in one time step.
  task automatic bus(input logic wr_n_rd, input logic [4:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    avs_address   <= a;
    avs_writedata <= {24'h000000, d};
    avs_write     <= wr_n_rd;
    avs_read      <= ~wr_n_rd;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clock);
    if (n >= 50) begin
      n_mismatch++;
      test_done();
    end
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q, {24'h000000, exp});
  endtask : rd

  // Each level is held long enough for the two-flop synchroniser.
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      drive_level <= 1'b1;
      repeat (6) @(posedge clock);
      drive_level <= 1'b0;
      repeat (6) @(posedge clock);
    end
  endtask : pulses

  task automatic tick();
    tick_req <= 1'b1;
    @(posedge clock);
    tick_req <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : tick

  task automatic cmp(input logic [3:0] mode, input logic [15:0] val, input logic [15:0] t0);
    int n;
    wr(ccp_pkg::FLAGS_OFS, 8'h03);
    wr(ccp_pkg::VALUE_LOW_OFS, val[7:0]);
    wr(ccp_pkg::VALUE_HIGH_OFS, val[15:8]);
    wr(ccp_pkg::TIMER_LOW_OFS, t0[7:0]);
    wr(ccp_pkg::TIMER_HIGH_OFS, t0[15:8]);
    wr(ccp_pkg::TIMER_CTRL_OFS, 8'h03);
    wr(ccp_pkg::CTRL_OFS, {4'h0, mode});
    trig_base = trig_cnt;
    adc_base  = adc_cnt;
    n = 0;
    while (irq_flag !== 1'b1 && n < 300) begin
      tick();
      n++;
    end
    if (n >= 300) begin
      n_mismatch++;
      test_done();
    end
  endtask : cmp

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    sleep = 1'b0;
    drive_level = 1'b0;
    tick_req = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    adc_en = 1'b1;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rd(ccp_pkg::FLAGS_OFS, 8'h00);
    rd(5'h1C, 8'h00);
    wr(ccp_pkg::TIMER_LOW_OFS, 8'h34);
    wr(ccp_pkg::TIMER_HIGH_OFS, 8'h12);
    wr(ccp_pkg::CTRL_OFS, {4'h0, ccp_pkg::MODE_CAP_RISE});
    pulses(1);
    rd(ccp_pkg::VALUE_LOW_OFS, 8'h34);
    rd(ccp_pkg::VALUE_HIGH_OFS, 8'h12);
    wr(ccp_pkg::TIMER_LOW_OFS, 8'h56);
    pulses(1);
    rd(ccp_pkg::VALUE_LOW_OFS, 8'h56);
    rd(ccp_pkg::FLAGS_OFS, 8'h01);
    wr(ccp_pkg::FLAGS_OFS, 8'h01);
    rd(ccp_pkg::FLAGS_OFS, 8'h00);
    drive_level <= 1'b1;
    wr(ccp_pkg::CTRL_OFS, {4'h0, ccp_pkg::MODE_CAP_FALL});
    wr(ccp_pkg::TIMER_LOW_OFS, 8'h78);
    pulses(0);
    drive_level <= 1'b0;
    repeat (6) @(posedge clock);
    rd(ccp_pkg::VALUE_LOW_OFS, 8'h78);
    wr(ccp_pkg::CTRL_OFS, 8'h00);
    wr(ccp_pkg::FLAGS_OFS, 8'h01);
    wr(ccp_pkg::CTRL_OFS, {4'h0, ccp_pkg::MODE_CAP_4});
    pulses(3);
    rd(ccp_pkg::FLAGS_OFS, 8'h00);
    pulses(1);
    rd(ccp_pkg::FLAGS_OFS, 8'h01);
    wr(ccp_pkg::FLAGS_OFS, 8'h01);
    pulses(2);
    wr(ccp_pkg::CTRL_OFS, 8'h00);
    wr(ccp_pkg::CTRL_OFS, {4'h0, ccp_pkg::MODE_CAP_4});
    pulses(3);
    rd(ccp_pkg::FLAGS_OFS, 8'h00);
    wr(ccp_pkg::CTRL_OFS, {4'h0, ccp_pkg::MODE_CAP_16});
    pulses(12);
    rd(ccp_pkg::FLAGS_OFS, 8'h00);
    pulses(1);
    rd(ccp_pkg::FLAGS_OFS, 8'h01);
    wr(ccp_pkg::CTRL_OFS, 8'h00);
    sleep <= 1'b1;
    wr(ccp_pkg::TIMER_LOW_OFS, 8'h10);
    wr(ccp_pkg::TIMER_CTRL_OFS, 8'h01);
    repeat (20) @(posedge clock);
    rd(ccp_pkg::TIMER_LOW_OFS, 8'h10);
    sleep <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      cmp(md[i], 16'h0203, 16'h0100);
      rd(ccp_pkg::TIMER_HIGH_OFS, 8'h02);
      check({31'h0, pin_oe_n}, {31'h0, exp_oe[i]});
      check(32'(trig_cnt - trig_base), {31'h0, exp_trig[i]});
      check(32'(adc_cnt - adc_base), {31'h0, exp_trig[i]});
      if (i < 3) check({31'h0, pin_out}, {31'h0, exp_pin[i]});
    end
    tick();
    rd(ccp_pkg::TIMER_LOW_OFS, 8'h00);
    rd(ccp_pkg::TIMER_HIGH_OFS, 8'h00);
    rd(ccp_pkg::FLAGS_OFS, 8'h01);
    wr(ccp_pkg::CTRL_OFS, 8'h00);
    repeat (2) @(posedge clock);
    check({31'h0, pin_out}, 32'h00000000);
    adc_en <= 1'b0;
    cmp(ccp_pkg::MODE_SPECIAL, 16'h0005, 16'h0000);
    check(32'(trig_cnt - trig_base), 32'h00000001);
    check(32'(adc_cnt - adc_base), 32'h00000000);
    wr(ccp_pkg::VALUE_LOW_OFS, 8'h09);
    tick();
    rd(ccp_pkg::TIMER_LOW_OFS, 8'h06);
    cmp(ccp_pkg::MODE_SPECIAL, 16'hFFFF, 16'hFFF0);
    tick();
    rd(ccp_pkg::TIMER_HIGH_OFS, 8'h00);
    check({31'h0, ovf_flag}, 32'h00000000);
    check({31'h0, irq_flag}, 32'h00000001);
    wr(ccp_pkg::CTRL_OFS, 8'h00);
    wr(ccp_pkg::TIMER_HIGH_OFS, 8'hFF);
    wr(ccp_pkg::TIMER_LOW_OFS, 8'hFF);
    tick();
    rd(ccp_pkg::FLAGS_OFS, 8'h03);
    check({31'h0, ovf_flag}, 32'h00000001);
    test_done();
  end
endmodule : ccp_capture_compare_unit_bench
`default_nettype wire
